// file: rtl/hscp_pkg.sv
// shared constants for the host serial control port
package hscp_pkg;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS = 7;
  localparam int DATA_BITS = 8;
  localparam int CNT_BITS = 5;
  localparam int DIR_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 8;
  localparam logic DIR_READ = 1'b1;
  localparam int NUM_REGS = 128;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int CLK_MHZ = 200;
  localparam int SCLK_MAX_MHZ = 10;
  // half period of the generated shift clock in cycles, rounded up
  localparam int SCLK_HALF_CYC = (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  localparam int HALF_BITS = 4;
  localparam int IRQ_BITS = 8;
endpackage

// file: rtl/hscp_if.sv
// serial control link between host and device
`timescale 1ns/1ps
interface hscp_if;
  logic sclk;
  logic sel_n;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic irq_n;
  logic irq_n_oe;
  modport device (input sclk, input sel_n, input serial_in,
    output serial_out, output serial_out_oe, output irq_n, output irq_n_oe);
  modport host (output sclk, output sel_n, output serial_in,
    input serial_out, input serial_out_oe, input irq_n, input irq_n_oe);
endinterface

// file: rtl/hscp_device.sv
// device end: serial command register port with interrupt request
`timescale 1ns/1ps
module hscp_device #(
  parameter int N_IRQ = hscp_pkg::IRQ_BITS,
  parameter int N_REGS = hscp_pkg::NUM_REGS
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // hardware reset pin, pulled up
  input wire logic hw_reset_n,
  // mode strap: high selects host mode
  input wire logic host_mode,
  // link
  hscp_if.device link,
  // interrupt sources and service from the core
  input wire logic [N_IRQ-1:0] irq_src,
  input wire logic [N_IRQ-1:0] irq_ack,
  // hardware mode mute input, sampled from the shared pin
  input wire logic mute_pin,
  output logic loss_mute_input,
  // register contents to the core
  output logic [hscp_pkg::DATA_BITS-1:0] reg_out [N_REGS],
  output logic [N_IRQ-1:0] irq_pending
);
  // pin synchronisers; the clock has a third stage for its edge finder
  logic [2:0] sclk_s_q;
  logic [1:0] sel_s_q;
  logic [1:0] sdi_s_q;
  logic [1:0] hwr_s_q;
  logic [1:0] mute_s_q;
  logic [1:0] mode_s_q;
  logic rise;
  logic fall;
  logic active;
  logic [hscp_pkg::CNT_BITS-1:0] cnt_q;
  logic [hscp_pkg::FRAME_BITS-1:0] shift_q;
  logic [hscp_pkg::DATA_BITS-1:0] rdata_q;
  logic is_read_q;
  logic sdo_q;
  logic oe_q;
  logic [hscp_pkg::DATA_BITS-1:0] regs_q [N_REGS];
  logic [N_IRQ-1:0] pend_q;
  logic [N_IRQ-1:0] irq_en;
  logic [hscp_pkg::ADDR_BITS-1:0] addr_w;

  // pin synchronisers; second stage feeds logic, and the clock's third stage too
  // the mode strap resets to hardware mode so the shared pin is not driven early
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_s_q <= 3'h0;
      sel_s_q <= 2'h3;
      sdi_s_q <= 2'h0;
      hwr_s_q <= 2'h3;
      mute_s_q <= 2'h0;
      mode_s_q <= 2'h0;
    end
    else if (clk_en)
    begin
      sclk_s_q <= {sclk_s_q[1:0], link.sclk};
      sel_s_q <= {sel_s_q[0], link.sel_n};
      sdi_s_q <= {sdi_s_q[0], link.serial_in};
      hwr_s_q <= {hwr_s_q[0], hw_reset_n};
      mute_s_q <= {mute_s_q[0], mute_pin};
      mode_s_q <= {mode_s_q[0], host_mode};
    end
  end

  // edge detection on the stages after the first
  // both stages idle low after reset, so no false rise follows it
  assign rise = sclk_s_q[1] & ~sclk_s_q[2];
  assign fall = ~sclk_s_q[1] & sclk_s_q[2];
  assign active = ~sel_s_q[1] & mode_s_q[1];

  // bit counter and input shifter
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q <= '0;
      shift_q <= '0;
    end
    else if (clk_en)
    begin
      if (!active)
        cnt_q <= '0;
      // rises past the sixteenth are ignored until select goes high
      else if (rise && cnt_q < 5'(hscp_pkg::FRAME_BITS))
      begin
        shift_q <= {shift_q[hscp_pkg::FRAME_BITS-2:0], sdi_s_q[1]};
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // address is complete once direction and seven address bits are in
  assign addr_w = shift_q[hscp_pkg::ADDR_BITS-1:0];

  // read path: latch data after address, shift out on falling edges
  // a frame cut short by select rising drops the output enable at once
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      is_read_q <= 1'b0;
      rdata_q <= '0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!active)
        oe_q <= 1'b0;
      else if (rise && cnt_q == 5'h00)
        is_read_q <= sdi_s_q[1] == hscp_pkg::DIR_READ;
      // load on the eighth rise, half a period before bit seven goes out
      else if (rise && cnt_q == 5'h07)
        rdata_q <= regs_q[{addr_w[5:0], sdi_s_q[1]}];
      else if (fall && is_read_q && cnt_q >= 5'h08 && cnt_q < 5'h10)
      begin
        sdo_q <= rdata_q[hscp_pkg::DATA_BITS-1];
        rdata_q <= {rdata_q[hscp_pkg::DATA_BITS-2:0], 1'b0};
        oe_q <= 1'b1;
      end
      else if (fall && cnt_q == 5'h10)
        oe_q <= 1'b0;
    end
  end

  // command registers; register 0 holds the interrupt enables
  // the pin reset wins over a write landing in the same cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < N_REGS; i++)
        regs_q[i] <= hscp_pkg::REG_RESET;
    end
    else if (clk_en)
    begin
      if (!hwr_s_q[1])
      begin
        for (int i = 0; i < N_REGS; i++)
          regs_q[i] <= hscp_pkg::REG_RESET;
      end
      else if (active && rise && cnt_q == 5'h0f && !is_read_q)
        regs_q[shift_q[hscp_pkg::ADDR_MSB-1:hscp_pkg::ADDR_LSB-1]] <=
          {shift_q[hscp_pkg::DATA_BITS-2:0], sdi_s_q[1]};
    end
  end

  assign irq_en = regs_q[0][N_IRQ-1:0];

  // sticky pending bits; a new event wins over its service
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pend_q <= '0;
    else if (clk_en)
    begin
      if (!hwr_s_q[1])
        pend_q <= '0;
      else
        pend_q <= (pend_q & ~irq_ack) | (irq_src & irq_en);
    end
  end

  // interrupt pin drives only in host mode, else it is the mute input
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      link.irq_n <= 1'b1;
    else if (clk_en)
      link.irq_n <= ~|(pend_q & irq_en);
  end

  // in hardware mode the interrupt pin is an input and is never driven
  assign link.irq_n_oe = mode_s_q[1];
  assign loss_mute_input = mode_s_q[1] ? 1'b0 : mute_s_q[1];
  // enable follows select too, so a cut frame releases the data pin
  assign link.serial_out = sdo_q;
  assign link.serial_out_oe = oe_q & active;
  assign irq_pending = pend_q;
  // register contents copied out for the core
  always_comb
  begin
    for (int i = 0; i < N_REGS; i++)
      reg_out[i] = regs_q[i];
  end
endmodule

// file: rtl/hscp_host.sv
// host end: drives select, shift clock and frames, collects read data
`timescale 1ns/1ps
module hscp_host (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // link
  hscp_if.host link,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic [hscp_pkg::ADDR_BITS-1:0] req_addr,
  input wire logic [hscp_pkg::DATA_BITS-1:0] req_wdata,
  // answer
  output logic rsp_valid,
  output logic [hscp_pkg::DATA_BITS-1:0] rsp_rdata,
  output logic irq_seen
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b10,
    ST_DONE = 2'b11
  } hscp_state_t;
  hscp_state_t st_q;
  logic [hscp_pkg::HALF_BITS-1:0] half_q;
  logic [hscp_pkg::CNT_BITS-1:0] bit_q;
  logic [hscp_pkg::FRAME_BITS-1:0] frame_q;
  logic [hscp_pkg::DATA_BITS-1:0] rx_q;
  logic [1:0] sdo_s_q;
  logic [1:0] irq_s_q;
  logic half_done;

  assign half_done = half_q == 4'(hscp_pkg::SCLK_HALF_CYC - 1);

  // pin synchronisers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sdo_s_q <= 2'h0;
      irq_s_q <= 2'h3;
    end
    else if (clk_en)
    begin
      sdo_s_q <= {sdo_s_q[0], link.serial_out};
      irq_s_q <= {irq_s_q[0], link.irq_n};
    end
  end

  // divider sets 10 MHz, sixteen periods under one select
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= ST_IDLE;
      half_q <= '0;
      bit_q <= '0;
      frame_q <= '0;
      rx_q <= '0;
      link.sclk <= 1'b0;
      link.sel_n <= 1'b1;
      link.serial_in <= 1'b0;
      rsp_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      rsp_valid <= 1'b0;
      half_q <= half_done ? 4'h0 : half_q + 4'h1;
      case (st_q)
        ST_IDLE:
          if (req_valid && half_done)
          begin
            // direction bit goes out with select, half a period before the first rise
            link.serial_in <= req_read;
            frame_q <= {req_addr, req_wdata, 1'b0};
            link.sel_n <= 1'b0;
            bit_q <= '0;
            half_q <= '0;
            st_q <= ST_LOW;
          end
        ST_LOW:
          if (half_done)
          begin
            link.sclk <= 1'b1;
            st_q <= ST_HIGH;
          end
        ST_HIGH:
          if (half_done)
          begin
            // next bit changes with the fall, so it is settled at the next rise
            link.sclk <= 1'b0;
            link.serial_in <= frame_q[hscp_pkg::FRAME_BITS-1];
            frame_q <= {frame_q[hscp_pkg::FRAME_BITS-2:0], 1'b0};
            // the bit seen now was driven after the previous fall
            if (bit_q >= 5'h08)
              rx_q <= {rx_q[hscp_pkg::DATA_BITS-2:0], sdo_s_q[1]};
            bit_q <= bit_q + 5'h01;
            st_q <= (bit_q == 5'(hscp_pkg::FRAME_BITS - 1)) ? ST_DONE : ST_LOW;
          end
        ST_DONE:
          if (half_done)
          begin
            link.sel_n <= 1'b1;
            rsp_valid <= 1'b1;
            st_q <= ST_IDLE;
          end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // requests are taken only on a half-period boundary, so select rests high ten cycles
  assign req_ready = (st_q == ST_IDLE) && half_done;
  assign rsp_rdata = rx_q;
  assign irq_seen = ~irq_s_q[1];
endmodule

// file: tb/hscp_sva.sv
// checker for the serial control link between host and device
`timescale 1ns/1ps
module hscp_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // link
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic irq_n
);
  logic sclk_q;
  logic [4:0] rise_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // previous shift clock level, for edge finding
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sclk_q <= 1'b0;
    else
      sclk_q <= sclk;
  end
  // rises in the current frame; cleared while deselected
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rise_q <= 5'h00;
    else if (sel_n)
      rise_q <= 5'h00;
    else if (sclk && !sclk_q)
      rise_q <= rise_q + 5'h01;
  end
  edge_sel_a: assert property ($rose(sclk) |-> !sel_n)
    else $error("clock rose while deselected");
  high_time_a: assert property ($rose(sclk) |-> sclk[*8] ##1 sclk[*2])
    else $error("clock high phase too short");
  low_time_a: assert property ($fell(sclk) |-> !sclk[*8] ##1 !sclk[*2])
    else $error("clock low phase too short");
  frame_len_a: assert property ($rose(sel_n) |-> rise_q == 5'h10)
    else $error("frame not sixteen periods");
  sel_hold_a: assert property ($fell(sel_n) |-> !sel_n[*8])
    else $error("select released early");
  frame_gap_a: assert property ($rose(sel_n) |-> sel_n[*8])
    else $error("select gap too short");
  out_fall_a: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
    |-> !sclk)
    else $error("read data moved with clock high");
  rd_start_a: assert property ($rose(serial_out_oe) |-> rise_q == 5'h08 && !sel_n)
    else $error("read data driven at wrong bit");
  out_release_a: assert property ($rose(sel_n) |-> ##[0:30] !serial_out_oe)
    else $error("data output not released");
  // main scenarios
  rd_c: cover property ($rose(serial_out_oe));
  end_c: cover property ($rose(sel_n));
  irq_c: cover property ($fell(irq_n));
endmodule

// file: tb/tb_host_serial_control_port.sv
// self-checking bench: host end and device end joined by the link
`timescale 1ns/1ps
module tb_host_serial_control_port;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic hw_reset_n = 1'b1;
  logic host_mode = 1'b1;
  logic mute_pin = 1'b0;
  logic [7:0] irq_src = 8'h00;
  logic [7:0] irq_ack = 8'h00;
  logic req_valid = 1'b0;
  logic req_read = 1'b0;
  logic [6:0] req_addr = 7'h00;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, rsp_valid, irq_seen, loss_mute_input;
  logic [7:0] rsp_rdata, irq_pending;
  logic [7:0] reg_out [128];
  logic [7:0] mdl [128];
  int err_total = 0;
  int checks = 0;
  hscp_if link ();
  hscp_device hscp_device_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .hw_reset_n(hw_reset_n), .host_mode(host_mode), .link(link), .irq_src(irq_src),
    .irq_ack(irq_ack), .mute_pin(mute_pin), .loss_mute_input(loss_mute_input),
    .reg_out(reg_out), .irq_pending(irq_pending));
  hscp_host hscp_host_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .link(link),
    .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .irq_seen(irq_seen));
  hscp_sva hscp_sva_inst (.clk(clk), .reset_n(reset_n), .sclk(link.sclk),
    .sel_n(link.sel_n), .serial_out(link.serial_out),
    .serial_out_oe(link.serial_out_oe), .irq_n(link.irq_n));
  always #2.5 clk = ~clk;
  task automatic results();
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] want(input logic [6:0] a);
    return mdl[a];
  endfunction
  // one request, held until taken, then a bounded wait for the answer
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_read <= rd;
    req_addr <= a;
    req_wdata <= d;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 2000);
    @(posedge clk);
    req_valid <= 1'b0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 2000);
    if (rsp_valid !== 1'b1)
    begin
      err_total++;
      results();
    end
  endtask
  initial
  begin
    logic [6:0] a;
    logic [7:0] d;
    void'($urandom(344));
    foreach (mdl[i]) mdl[i] = 8'h00;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk(reg_out[7'h05], want(7'h05));
    // a frozen enable holds both ends; a waiting request is not taken
    @(posedge clk);
    clk_en <= 1'b0;
    req_valid <= 1'b1;
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk(link.sel_n, 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    clk_en <= 1'b1;
    // corner values first, then random writes, each read back
    for (int i = 0; i < 8; i++)
    begin
      a = (i == 0) ? 7'h7f : (i == 1) ? 7'h01 : 7'($urandom_range(1, 127));
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      xfer(1'b0, a, d);
      mdl[a] = d;
      chk(reg_out[a], want(a));
      xfer(1'b1, a, 8'h00);
      chk(rsp_rdata, want(a));
    end
    // enable source 0 only; a disabled source must not pull the line
    xfer(1'b0, 7'h00, 8'h01);
    mdl[0] = 8'h01;
    @(posedge clk);
    irq_src <= 8'h02;
    @(posedge clk);
    irq_src <= 8'h00;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(link.irq_n, 1'b1);
    chk(irq_pending, 8'h00);
    @(posedge clk);
    irq_src <= 8'h01;
    @(posedge clk);
    irq_src <= 8'h00;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(link.irq_n, 1'b0);
    chk(irq_seen, 1'b1);
    chk(irq_pending, 8'h01);
    repeat (20) @(negedge clk);
    chk(link.irq_n, 1'b0);
    @(posedge clk);
    irq_ack <= 8'h03;
    @(posedge clk);
    irq_ack <= 8'h00;
    repeat (6) @(negedge clk);
    chk(link.irq_n, 1'b1);
    chk(irq_seen, 1'b0);
    // pin reset clears stored values and a pending event
    @(posedge clk);
    irq_src <= 8'h01;
    @(posedge clk);
    irq_src <= 8'h00;
    hw_reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    hw_reset_n <= 1'b1;
    repeat (4) @(negedge clk);
    foreach (mdl[i]) mdl[i] = 8'h00;
    chk(irq_pending, 8'h00);
    chk(link.irq_n, 1'b1);
    chk(reg_out[7'h00], want(7'h00));
    xfer(1'b1, 7'h7f, 8'h00);
    chk(rsp_rdata, want(7'h7f));
    // hardware mode turns the interrupt pin into the mute input
    @(posedge clk);
    host_mode <= 1'b0;
    mute_pin <= 1'b1;
    repeat (6) @(negedge clk);
    chk(loss_mute_input, 1'b1);
    chk(link.irq_n_oe, 1'b0);
    @(posedge clk);
    host_mode <= 1'b1;
    mute_pin <= 1'b0;
    repeat (6) @(negedge clk);
    chk(link.irq_n_oe, 1'b1);
    chk(loss_mute_input, 1'b0);
    results();
  end
endmodule
